// *** bench/rtc_core_assertions.sv ***
`timescale 1ns/100ps
module rtc_core_assertions
    import rtc_pkg::*;
(
    input wire logic        clk,              // Clock.
    input wire logic        rst_b,            // Reset.
    input wire logic        ce,               // Enable.
    input wire logic        wdt_rst,          // Watchdog.
    input wire logic        osc_slow_en,      // Osc pulse.
    input wire logic        main_div_slow_en, // Main pulse.
    input wire logic        main_power_down,  // Power down.
    input wire logic        psel,             // Select.
    input wire logic        penable,          // Enable.
    input wire logic        pwrite,           // Write.
    input wire logic [31:0] paddr,            // Address.
    input wire logic [31:0] pwdata,           // Write data.
    input wire logic [31:0] prdata,           // Read data.
    input wire logic        pready,           // Ready.
    input wire logic        pslverr,          // Error.
    input wire logic        irq,              // Interrupt.
    input wire logic        slow_source_sel   // Source.
);
    logic unmapped;
    assign unmapped = !(paddr inside {CTRL_ADDR, SEC_ADDR, ALARM_ADDR, REGUL_ADDR,
                                      IRQ_STAT_ADDR, IRQ_MASK_ADDR});

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence setup_s;
        psel && !penable && ce;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence

    ready_after_setup_a: assert property (setup_s |=> access_s)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    unmapped_err_a: assert property (pready |-> pslverr == unmapped)
        else $error("pslverr does not match address map");
    rdata_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("prdata changed outside a read");
    source_forced_a: assert property (main_power_down |=> !slow_source_sel)
        else $error("source not forced during power down");
    source_rise_a: assert property ($rose(slow_source_sel) |-> $past(main_power_down) == 1'b0)
        else $error("source rose while powered down");
    reset_quiet_a: assert property (disable iff (1'b0)
        !rst_b |=> !pready && !pslverr && !irq && !slow_source_sel)
        else $error("outputs active after reset");
endmodule

bind rtc_core rtc_core_assertions u_rtc_core_assertions (
    .clk(clk), .rst_b(rst_b), .ce(ce), .wdt_rst(wdt_rst), .osc_slow_en(osc_slow_en),
    .main_div_slow_en(main_div_slow_en), .main_power_down(main_power_down),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .slow_source_sel(slow_source_sel)
);

// *** bench/rtc_core_tb.sv ***
`timescale 1ns/100ps
module rtc_core_tb;
    import rtc_pkg::*;
    logic        clk, rst_b, ce, wdt_rst, osc_slow_en, main_div_slow_en, main_power_down;
    logic        psel, penable, pwrite, pready, pslverr, irq, slow_source_sel, err;
    logic [31:0] paddr, pwdata, prdata, rd, s0, v;
    int          fail_count, checks_done, seed, cnt;

    rtc_core u_rtc_core (.clk(clk), .rst_b(rst_b), .ce(ce), .wdt_rst(wdt_rst),
        .osc_slow_en(osc_slow_en), .main_div_slow_en(main_div_slow_en),
        .main_power_down(main_power_down), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .slow_source_sel(slow_source_sel));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Slow pulses every 3 and 4 cycles keep tick periods short but distinct.
    always @(posedge clk) begin
        cnt <= cnt + 1;
        osc_slow_en <= (cnt % 3 == 0);
        main_div_slow_en <= (cnt % 4 == 0);
    end

    function automatic logic [31:0] exp_ticks(input int cyc, input int per);
        return cyc / (per * 3);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Writes are followed by a poll, since a second write before landing is lost.
    task automatic wait_rdy();
        do apb(1'b0, CTRL_ADDR, 32'h0); while (rd[CTRL_WRITE_LANDED_FLAG_BIT] !== 1'b1);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        wait_rdy();
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic measure(input int n, input logic [31:0] lo, input logic [31:0] hi);
        apb(1'b0, SEC_ADDR, 32'h0);
        s0 = rd;
        repeat (n) @(posedge clk);
        apb(1'b0, SEC_ADDR, 32'h0);
        chk(32'(rd - s0 >= lo && rd - s0 <= hi), 32'h1);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #(100 * 30000);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        fail_count = 0; checks_done = 0; seed = 88227;
        rst_b = 1'b0; ce = 1'b1; wdt_rst = 1'b0;
        main_power_down = 1'b0; psel = 1'b0;
        penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        rdc(CTRL_ADDR, CTRL_RESET);
        apb(1'b0, CTRL_ADDR + 32'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(SEC_ADDR, v);
            rdc(SEC_ADDR, v);
            wr(ALARM_ADDR, ~v);
            rdc(ALARM_ADDR, ~v);
        end
        apb(1'b1, CTRL_ADDR, 32'h80);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd & 32'h80, 32'h0);
        wait_rdy();
        rdc(CTRL_ADDR, 32'h80);
        $display("test registers done");
        for (int s = 0; s < 2; s++) begin
            wr(REGUL_ADDR, {6'h0, (s == 1) ? 10'h3ff : 10'h0, 16'h3});
            wr(CTRL_ADDR, 32'h1);
            measure(300, exp_ticks(303, 4 + s) - 1, exp_ticks(303, 4 + s) + 1);
            wr(CTRL_ADDR, 32'h40);
        end
        measure(300, 32'h0, 32'h0);
        rdc(CTRL_ADDR, 32'hc0);
        wr(CTRL_ADDR, 32'h60);
        chk({31'h0, irq}, 32'h1);
        wr(CTRL_ADDR, 32'h20);
        rdc(CTRL_ADDR, 32'ha0);
        chk({31'h0, irq}, 32'h0);
        wr(CTRL_ADDR, 32'h0);
        $display("test tick done");
        wr(SEC_ADDR, 32'd100);
        wr(ALARM_ADDR, 32'd102);
        wr(CTRL_ADDR, 32'h1d);
        repeat (60) @(posedge clk);
        wr(CTRL_ADDR, 32'h5c);
        rdc(CTRL_ADDR, 32'hdc);
        chk({31'h0, irq}, 32'h1);
        wr(CTRL_ADDR, 32'h54);
        chk({31'h0, irq}, 32'h0);
        wr(CTRL_ADDR, 32'h0);
        rdc(CTRL_ADDR, 32'h80);
        rdc(IRQ_STAT_ADDR, 32'h3);
        wr(IRQ_MASK_ADDR, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_STAT_ADDR, 32'h3);
        rdc(IRQ_STAT_ADDR, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(IRQ_MASK_ADDR, 32'h0);
        $display("test alarm done");
        // The clock controller is assumed prepared before the main source is chosen.
        wr(CTRL_ADDR, 32'h2);
        chk({31'h0, slow_source_sel}, 32'h1);
        main_power_down <= 1'b1;
        repeat (2) @(posedge clk);
        chk({31'h0, slow_source_sel}, 32'h0);
        main_power_down <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, slow_source_sel}, 32'h1);
        wr(CTRL_ADDR, 32'h0);
        wr(REGUL_ADDR, 32'h8000_0005);
        wr(REGUL_ADDR, 32'h7);
        rdc(REGUL_ADDR, 32'h8000_0005);
        wdt_rst <= 1'b1;
        @(posedge clk);
        wdt_rst <= 1'b0;
        rdc(CTRL_ADDR, 32'h80);
        wr(REGUL_ADDR, 32'h7);
        rdc(REGUL_ADDR, 32'h7);
        // A tick takes 24 cycles now, so a frozen 200-cycle span shows at most one step.
        wr(CTRL_ADDR, 32'h1);
        apb(1'b0, SEC_ADDR, 32'h0);
        s0 = rd;
        ce <= 1'b0;
        repeat (200) @(posedge clk);
        ce <= 1'b1;
        apb(1'b0, SEC_ADDR, 32'h0);
        chk(32'(rd - s0 <= 32'h1), 32'h1);
        wr(CTRL_ADDR, 32'h0);
        v = $random(seed);
        wr(SEC_ADDR, v);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rdc(CTRL_ADDR, CTRL_RESET);
        rdc(SEC_ADDR, v);
        rdc(SEC_ADDR, v);
        $display("test resets done");
        tally_and_finish();
    end
endmodule

// *** hw/rtc_core.sv ***
`timescale 1ns/100ps
module rtc_core #(
    parameter int PERIOD_W  = 16,
    parameter int STRETCH_W = 10
) (
    input  wire logic        clk,               // System clock, 10 MHz.
    input  wire logic        rst_b,             // Pin or wakeup reset, synchronous, active low.
    input  wire logic        ce,                // Clock enable, freezes all state when low except under the pin reset.
    input  wire logic        wdt_rst,           // Watchdog reset pulse, active high.
    input  wire logic        osc_slow_en,       // One cycle of the 32 kHz oscillator.
    input  wire logic        main_div_slow_en,  // One cycle of the divided main clock.
    input  wire logic        main_power_down,   // Main chip power is down.
    input  wire logic        psel,              // APB select.
    input  wire logic        penable,           // APB enable.
    input  wire logic        pwrite,            // APB write.
    input  wire logic [31:0] paddr,             // APB address.
    input  wire logic [31:0] pwdata,            // APB write data.
    output logic      [31:0] prdata,            // APB read data.
    output logic             pready,            // APB ready.
    output logic             pslverr,           // APB error on unmapped address.
    output logic             irq,               // Interrupt request, level.
    output logic             slow_source_sel    // Effective slow clock source.
);
    import rtc_pkg::*;

    if (PERIOD_W != REG_PERIOD_MSB - REG_PERIOD_LSB + 1) begin : g_bad_period
        $error("rtc_core: period width must match the regulator field");
    end
    if (STRETCH_W != REG_STRETCH_MSB - REG_STRETCH_LSB + 1) begin : g_bad_stretch
        $error("rtc_core: stretch width must match the regulator field");
    end

    function automatic reg_sel_t decode(input logic [31:0] addr);
        case (addr)
            CTRL_ADDR:     decode = SEL_CTRL;
            SEC_ADDR:      decode = SEL_SEC;
            ALARM_ADDR:    decode = SEL_ALARM;
            REGUL_ADDR:    decode = SEL_REGUL;
            IRQ_STAT_ADDR: decode = SEL_STAT;
            IRQ_MASK_ADDR: decode = SEL_MASK;
            default:       decode = SEL_NONE;
        endcase
    endfunction

    // Control fields.
    logic                 run_r;
    logic                 div_sel_r;
    logic                 alarm_en_r;
    logic                 alarm_ie_r;
    logic                 alarm_flag_r;
    logic                 tick_ie_r;
    logic                 tick_flag_r;
    // Timekeeping and regulator.
    logic [31:0]          sec_r;
    logic [31:0]          alarm_r;
    logic [PERIOD_W-1:0]  period_r;
    logic [STRETCH_W-1:0] stretch_r;
    logic                 lock_r;
    // Interrupt status and mask.
    logic [1:0]           stat_r;
    logic [1:0]           mask_r;
    // Write crossing.
    wr_state_t            wr_state_r;
    logic [1:0]           slow_cnt_r;
    reg_sel_t             pend_sel_r;
    logic [31:0]          pend_data_r;
    // Alarm edge detection.
    logic                 alarm_qual_prev_r;
    // Bus, interrupt and source outputs.
    logic [31:0]          prdata_r;
    logic                 pready_r;
    logic                 pslverr_r;
    logic                 irq_r;
    logic                 src_sel_r;

    logic       eff_sel;
    logic       slow_en;
    logic       setup;
    logic       wr_acc;
    reg_sel_t   acc_sel;
    reg_sel_t   setup_sel;
    logic       wr_start;
    logic       land;
    logic       tick;
    logic       tick_event;
    logic       alarm_qual;
    logic       alarm_event;
    logic       ctrl_wr;
    logic       ctrl_land;
    logic [31:0] rd_data;

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign irq             = irq_r;
    assign slow_source_sel = src_sel_r;

    always_comb begin
        eff_sel     = div_sel_r & ~main_power_down;
        slow_en     = eff_sel ? main_div_slow_en : osc_slow_en;
        setup       = psel & ~penable;
        setup_sel   = decode(paddr);
        acc_sel     = decode(paddr);
        wr_acc      = psel & penable & pready_r & pwrite & ~pslverr_r;
        ctrl_wr     = wr_acc & (acc_sel == SEL_CTRL);
        // Writes arriving while one is pending are dropped; software must poll first.
        wr_start    = wr_acc & (wr_state_r == WR_IDLE)
                      & (acc_sel inside {SEL_CTRL, SEL_SEC, SEL_ALARM, SEL_REGUL})
                      & ~((acc_sel == SEL_REGUL) & lock_r);
        land        = (wr_state_r == WR_WAIT) & slow_en
                      & (slow_cnt_r == WR_LAND_SLOW - 2'h1);
        ctrl_land   = land & (pend_sel_r == SEL_CTRL);
        tick_event  = tick & run_r;
        alarm_qual  = (sec_r == alarm_r) & alarm_en_r & run_r;
        alarm_event = alarm_qual & ~alarm_qual_prev_r;
    end

    tick_gen #(
        .PERIOD_W  (PERIOD_W),
        .STRETCH_W (STRETCH_W)
    ) u_tick_gen (
        .clk     (clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .run     (run_r),
        .slow_en (slow_en),
        .period  (period_r),
        .stretch (stretch_r),
        .tick    (tick)
    );

    // Write crossing: the value lands on the second slow cycle, then one more settles.
    always_ff @(posedge clk) begin
        if (!rst_b || (ce && wdt_rst)) begin
            wr_state_r  <= WR_IDLE;
            slow_cnt_r  <= 2'h0;
            pend_sel_r  <= SEL_NONE;
            pend_data_r <= 32'h0000_0000;
        end else if (ce) begin
            case (wr_state_r)
                WR_IDLE: begin
                    if (wr_start) begin
                        wr_state_r  <= WR_WAIT;
                        slow_cnt_r  <= 2'h0;
                        pend_sel_r  <= acc_sel;
                        pend_data_r <= pwdata;
                    end
                end
                WR_WAIT: begin
                    if (land) begin
                        wr_state_r <= WR_SETTLE;
                        slow_cnt_r <= 2'h0;
                    end else if (slow_en) begin
                        slow_cnt_r <= slow_cnt_r + 2'h1;
                    end
                end
                WR_SETTLE: begin
                    if (slow_en) begin
                        if (slow_cnt_r == WR_SETTLE_SLOW - 2'h1) begin
                            wr_state_r <= WR_IDLE;
                        end else begin
                            slow_cnt_r <= slow_cnt_r + 2'h1;
                        end
                    end
                end
                default: begin
                    wr_state_r <= WR_IDLE;
                end
            endcase
        end
    end

    // Control fields that cross with the write; the watchdog leaves them alone.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_r      <= CTRL_RESET[CTRL_RUN_BIT];
            div_sel_r  <= CTRL_RESET[CTRL_SEL_BIT];
            alarm_en_r <= CTRL_RESET[CTRL_AE_BIT];
            alarm_ie_r <= CTRL_RESET[CTRL_AIE_BIT];
        end else if (ce && ctrl_land) begin
            run_r      <= pend_data_r[CTRL_RUN_BIT];
            div_sel_r  <= pend_data_r[CTRL_SEL_BIT];
            alarm_en_r <= pend_data_r[CTRL_AE_BIT];
            alarm_ie_r <= pend_data_r[CTRL_AIE_BIT];
        end
    end

    // Tick enable acts on the bus write itself, without the crossing delay.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tick_ie_r <= CTRL_RESET[CTRL_TIE_BIT];
        end else if (ce && ctrl_wr) begin
            tick_ie_r <= pwdata[CTRL_TIE_BIT];
        end
    end

    // Flags clear at once on a written zero; a fresh event wins over the clear.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tick_flag_r  <= CTRL_RESET[CTRL_TF_BIT];
            alarm_flag_r <= CTRL_RESET[CTRL_AF_BIT];
        end else if (ce) begin
            if (tick_event) begin
                tick_flag_r <= 1'b1;
            end else if (ctrl_wr && !pwdata[CTRL_TF_BIT]) begin
                tick_flag_r <= 1'b0;
            end
            if (alarm_event) begin
                alarm_flag_r <= 1'b1;
            end else if (ctrl_wr && !pwdata[CTRL_AF_BIT]) begin
                alarm_flag_r <= 1'b0;
            end
        end
    end

    // Seconds and alarm values have no reset so time survives every reset.
    always_ff @(posedge clk) begin
        if (ce) begin
            if (land && pend_sel_r == SEL_SEC) begin
                sec_r <= pend_data_r;
            end else if (tick_event) begin
                sec_r <= sec_r + 32'h0000_0001;
            end
            if (land && pend_sel_r == SEL_ALARM) begin
                alarm_r <= pend_data_r;
            end
        end
    end

    // An alarm fires once when the qualified match begins, not every cycle it holds.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alarm_qual_prev_r <= 1'b0;
        end else if (ce) begin
            alarm_qual_prev_r <= alarm_qual;
        end
    end

    // Regulator fields; the lock clears on every reset.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            period_r  <= REG_PERIOD_RESET;
            stretch_r <= REG_STRETCH_RESET;
        end else if (ce && land && pend_sel_r == SEL_REGUL) begin
            period_r  <= pend_data_r[REG_PERIOD_MSB:REG_PERIOD_LSB];
            stretch_r <= pend_data_r[REG_STRETCH_MSB:REG_STRETCH_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || (ce && wdt_rst)) begin
            lock_r <= 1'b0;
        end else if (ce && land && pend_sel_r == SEL_REGUL
                     && pend_data_r[REG_LOCK_BIT]) begin
            lock_r <= 1'b1;
        end
    end

    // Sticky status, write one to clear, set wins over clear.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stat_r <= 2'h0;
            mask_r <= IRQ_MASK_RESET;
        end else if (ce) begin
            for (int i = 0; i < 2; i++) begin
                if ((i == IRQ_TICK_BIT && tick_event) || (i == IRQ_ALARM_BIT && alarm_event)) begin
                    stat_r[i] <= 1'b1;
                end else if (wr_acc && acc_sel == SEL_STAT && pwdata[i]) begin
                    stat_r[i] <= 1'b0;
                end
            end
            if (wr_acc && acc_sel == SEL_MASK) begin
                mask_r <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_r     <= 1'b0;
            src_sel_r <= 1'b0;
        end else if (ce) begin
            irq_r     <= (tick_flag_r & tick_ie_r)
                         | (alarm_flag_r & alarm_ie_r)
                         | (|(stat_r & mask_r));
            src_sel_r <= eff_sel;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        case (setup_sel)
            SEL_CTRL: begin
                rd_data[CTRL_RUN_BIT]  = run_r;
                rd_data[CTRL_SEL_BIT]  = div_sel_r;
                rd_data[CTRL_AE_BIT]   = alarm_en_r;
                rd_data[CTRL_AIE_BIT]  = alarm_ie_r;
                rd_data[CTRL_AF_BIT]   = alarm_flag_r;
                rd_data[CTRL_TIE_BIT]  = tick_ie_r;
                rd_data[CTRL_TF_BIT]   = tick_flag_r;
                rd_data[CTRL_WRITE_LANDED_FLAG_BIT] = (wr_state_r == WR_IDLE);
            end
            SEL_SEC:   rd_data = sec_r;
            SEL_ALARM: rd_data = alarm_r;
            SEL_REGUL: begin
                rd_data[REG_PERIOD_MSB:REG_PERIOD_LSB]   = period_r;
                rd_data[REG_STRETCH_MSB:REG_STRETCH_LSB] = stretch_r;
                rd_data[REG_LOCK_BIT]                    = lock_r;
            end
            SEL_STAT:  rd_data[1:0] = stat_r;
            SEL_MASK:  rd_data[1:0] = mask_r;
            default:   rd_data = 32'h0000_0000;
        endcase
    end

    // No wait states: data and ready are registered in the setup cycle.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            pready_r  <= setup;
            pslverr_r <= setup & (setup_sel == SEL_NONE);
            if (setup && !pwrite) begin
                prdata_r <= rd_data;
            end
        end
    end

endmodule

// *** hw/rtc_pkg.sv ***
package rtc_pkg;

    // Byte addresses of the register words.
    localparam logic [31:0] CTRL_ADDR      = 32'h1000_3000;
    localparam logic [31:0] SEC_ADDR       = 32'h1000_3004;
    localparam logic [31:0] ALARM_ADDR     = 32'h1000_3008;
    localparam logic [31:0] REGUL_ADDR     = 32'h1000_300c;
    localparam logic [31:0] IRQ_STAT_ADDR  = 32'h1000_3010;
    localparam logic [31:0] IRQ_MASK_ADDR  = 32'h1000_3014;

    // Control register field positions.
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_SEL_BIT   = 1;
    localparam int CTRL_AE_BIT    = 2;
    localparam int CTRL_AIE_BIT   = 3;
    localparam int CTRL_AF_BIT    = 4;
    localparam int CTRL_TIE_BIT   = 5;
    localparam int CTRL_TF_BIT    = 6;
    localparam int CTRL_WRITE_LANDED_FLAG_BIT  = 7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0081;

    // Regulator register field positions and reset values.
    localparam int REG_PERIOD_LSB  = 0;
    localparam int REG_PERIOD_MSB  = 15;
    localparam int REG_STRETCH_LSB = 16;
    localparam int REG_STRETCH_MSB = 25;
    localparam int REG_LOCK_BIT    = 31;
    localparam logic [15:0] REG_PERIOD_RESET  = 16'h7fff;
    localparam logic [9:0]  REG_STRETCH_RESET = 10'h000;

    // Interrupt status and mask bit positions.
    localparam int IRQ_TICK_BIT  = 0;
    localparam int IRQ_ALARM_BIT = 1;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // Slow clock cycles for a write to land, and the cycles before the next one.
    localparam logic [1:0] WR_LAND_SLOW   = 2'h2;
    localparam logic [1:0] WR_SETTLE_SLOW = 2'h1;

    // Pulses per stretch group.
    localparam int STRETCH_GROUP = 1024;

    typedef enum logic [2:0] {
        SEL_CTRL  = 3'b000,
        SEL_SEC   = 3'b001,
        SEL_ALARM = 3'b010,
        SEL_REGUL = 3'b011,
        SEL_STAT  = 3'b100,
        SEL_MASK  = 3'b101,
        SEL_NONE  = 3'b111
    } reg_sel_t;

    typedef enum logic [1:0] {
        WR_IDLE   = 2'b00,
        WR_WAIT   = 2'b01,
        WR_SETTLE = 2'b10
    } wr_state_t;

endpackage

// *** hw/tick_gen.sv ***
`timescale 1ns/100ps
module tick_gen #(
    parameter int PERIOD_W  = 16,
    parameter int STRETCH_W = 10
) (
    input  wire logic                 clk,      // System clock.
    input  wire logic                 rst_b,    // Synchronous reset, active low.
    input  wire logic                 ce,       // Clock enable.
    input  wire logic                 run,      // Timekeeping enabled.
    input  wire logic                 slow_en,  // One slow clock cycle elapsed.
    input  wire logic [PERIOD_W-1:0]  period,   // Tick period count.
    input  wire logic [STRETCH_W-1:0] stretch,  // Stretched pulses per group.
    output logic                      tick      // One-cycle tick pulse.
);
    import rtc_pkg::*;

    if (STRETCH_W != $clog2(STRETCH_GROUP)) begin : g_bad_stretch
        $error("tick_gen: stretch width must match the group size");
    end
    if (PERIOD_W < 2) begin : g_bad_period
        $error("tick_gen: period width too small");
    end

    logic [PERIOD_W:0]    cyc_r;
    logic [STRETCH_W-1:0] idx_r;
    logic [PERIOD_W:0]    last_cyc;

    // Stretched pulses come first in each group of the pulse index.
    always_comb begin
        last_cyc = {1'b0, period} + ((idx_r < stretch) ? 1'b1 : 1'b0);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cyc_r <= '0;
            idx_r <= '0;
            tick  <= 1'b0;
        end else if (ce) begin
            tick <= 1'b0;
            if (!run) begin
                cyc_r <= '0;
            end else if (slow_en) begin
                if (cyc_r >= last_cyc) begin
                    cyc_r <= '0;
                    idx_r <= idx_r + 1'b1;
                    tick  <= 1'b1;
                end else begin
                    cyc_r <= cyc_r + 1'b1;
                end
            end
        end
    end

endmodule
